// ===== design/word_accumulator_logic_unit.sv
// word accumulator datapath: load, compare and mask commands
`timescale 1ns/1ps
module word_accumulator_logic_unit
  import word_alu_pkg::*;
(
  input  wire logic                       clock,
  input  wire logic                       arst_n,
  input  wire logic                       command_valid,
  input  wire request_type                request,
  output logic [MAIN_ADDR_WIDTH-1:0]      main_read_address,
  input  wire logic [WORD_WIDTH-1:0]      main_read_data,
  output logic [SCR_NUM_WIDTH-1:0]        scratch_read_number,
  input  wire logic [WORD_WIDTH-1:0]      scratch_read_data,
  output logic [PER_NUM_WIDTH-1:0]        persistent_read_number,
  input  wire logic [WORD_WIDTH-1:0]      persistent_read_data,
  output scratch_write_type               scratch_write,
  output logic [WORD_WIDTH-1:0]           accumulator,
  output logic                            command_done,
  output logic                            operand_error
);

  // accumulator group
  logic [WORD_WIDTH-1:0] acc_reg;
  logic [WORD_WIDTH-1:0] acc_next;
  // scratch write-back group
  scratch_write_type     swr_reg;
  scratch_write_type     swr_next;
  // status pulse group
  logic                  done_reg;
  logic                  done_next;
  logic                  err_reg;
  logic                  err_next;

  // operand path and range checks
  logic [WORD_WIDTH-1:0] operand;
  logic                  main_bad;
  logic                  scr_src_bad;
  logic                  scr_dst_bad;
  logic                  per_bad;
  logic                  bad;

  // command decode
  logic                  use_main;
  logic                  use_scr_src;
  logic                  use_per;
  logic                  use_result;
  logic                  is_load;
  logic                  is_compare;
  logic                  is_mask;
  logic                  is_known;

  // comparison results
  logic                  acc_less;
  logic                  acc_equal;
  logic                  acc_greater;
  logic [WORD_WIDTH-1:0] flags;
  logic                  accept;
  logic                  proceed;

  // stores are read combinationally in the request cycle
  assign main_read_address      = request.main_register_address;
  assign scratch_read_number    = request.scratch_source_number;
  assign persistent_read_number = request.persistent_register_number;

  // every strobed cycle is one command
  assign accept  = command_valid;
  assign proceed = command_valid & ~bad;

  always_comb begin
    main_bad    = request.main_register_address >=
                  MAIN_ADDR_WIDTH'(MAIN_COUNT);
    scr_src_bad = request.scratch_source_number >= SCR_NUM_WIDTH'(SCR_COUNT);
    scr_dst_bad = request.scratch_result_number >= SCR_NUM_WIDTH'(SCR_COUNT);
    // spare top bit: a full store never wraps the limit
    per_bad     = {1'b0, request.persistent_register_number} >=
                  (PER_NUM_WIDTH + 1)'(PER_COUNT);
  end

  // command decode table
  always_comb begin
    use_main    = 1'b0;
    use_scr_src = 1'b0;
    use_per     = 1'b0;
    use_result  = 1'b0;
    is_load     = 1'b0;
    is_compare  = 1'b0;
    is_mask     = 1'b0;
    is_known    = 1'b1;

    case (request.command)
      load_constant_word: begin
        is_load = 1'b1;
      end

      load_main_word: begin
        is_load  = 1'b1;
        use_main = 1'b1;
      end

      load_scratch_word: begin
        is_load     = 1'b1;
        use_scr_src = 1'b1;
      end

      load_persistent_word: begin
        is_load = 1'b1;
        use_per = 1'b1;
      end

      compare_constant_word: begin
        is_compare = 1'b1;
        use_result = 1'b1;
      end

      compare_main_word: begin
        is_compare = 1'b1;
        use_main   = 1'b1;
        use_result = 1'b1;
      end

      compare_scratch_word: begin
        is_compare  = 1'b1;
        use_scr_src = 1'b1;
        use_result  = 1'b1;
      end

      compare_persistent_word: begin
        is_compare = 1'b1;
        use_per    = 1'b1;
        use_result = 1'b1;
      end

      mask_with_constant_word: begin
        is_mask = 1'b1;
      end

      mask_with_main_word: begin
        is_mask  = 1'b1;
        use_main = 1'b1;
      end

      mask_with_scratch_word: begin
        is_mask     = 1'b1;
        use_scr_src = 1'b1;
      end

      mask_with_persistent_word: begin
        is_mask = 1'b1;
        use_per = 1'b1;
      end

      // unknown codes are refused like bad operands
      default: begin
        is_known = 1'b0;
      end
    endcase
  end

  // only the operands a command uses can refuse it
  always_comb begin
    bad = ~is_known;
    if (use_main & main_bad) begin
      bad = 1'b1;
    end
    if (use_scr_src & scr_src_bad) begin
      bad = 1'b1;
    end
    if (use_per & per_bad) begin
      bad = 1'b1;
    end
    if (use_result & scr_dst_bad) begin
      bad = 1'b1;
    end
  end

  // operand source selection by the low two command bits
  always_comb begin
    case (request.command[1:0])
      2'b00:   operand = request.immediate_operand;
      2'b01:   operand = main_read_data;
      2'b10:   operand = scratch_read_data;
      default: operand = persistent_read_data;
    endcase
  end

  always_comb begin
    acc_less    = acc_reg < operand;
    acc_equal   = acc_reg == operand;
    acc_greater = acc_reg > operand;
  end

  // flag word, other bits stay clear
  always_comb begin
    flags                   = '0;
    flags[FLAG_LESS_BIT]    = acc_less;
    flags[FLAG_EQUAL_BIT]   = acc_equal;
    flags[FLAG_GREATER_BIT] = acc_greater;
  end

  // accumulator next value
  always_comb begin
    acc_next = acc_reg;
    if (proceed) begin
      if (is_load) begin
        acc_next = operand;
      end else if (is_mask) begin
        acc_next = acc_reg & operand;
      end
    end
  end

  // accumulator register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      acc_reg <= ACC_RESET;
    end else begin
      acc_reg <= acc_next;
    end
  end

  always_comb begin
    swr_next = '0;
    if (proceed & is_compare) begin
      swr_next.valid  = 1'b1;
      swr_next.number = request.scratch_result_number;
      swr_next.data   = flags;
    end
  end

  // write-back register, one-cycle pulse
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      swr_reg <= '0;
    end else begin
      swr_reg <= swr_next;
    end
  end

  always_comb begin
    done_next = accept;
    err_next  = accept & bad;
  end

  // status register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      done_reg <= 1'b0;
      err_reg  <= 1'b0;
    end else begin
      done_reg <= done_next;
      err_reg  <= err_next;
    end
  end

  // registered outputs
  assign accumulator   = acc_reg;
  assign scratch_write = swr_reg;
  assign command_done  = done_reg;
  assign operand_error = err_reg;

endmodule

// ===== design/word_alu_pkg.sv
// shared constants and types for the word accumulator logic unit
package word_alu_pkg;
  localparam int unsigned WORD_WIDTH      = 16;
  localparam int unsigned MAIN_ADDR_WIDTH = 11;
  localparam int unsigned SCR_NUM_WIDTH   = 9;
  localparam int unsigned PER_NUM_WIDTH   = 6;
  localparam int unsigned MAIN_COUNT      = 1400;
  localparam int unsigned SCR_COUNT       = 300;
  localparam int unsigned PER_COUNT       = 64;
  localparam int unsigned FLAG_LESS_BIT    = 1;
  localparam int unsigned FLAG_EQUAL_BIT   = 2;
  localparam int unsigned FLAG_GREATER_BIT = 3;
  localparam logic [15:0] ACC_RESET = 16'h0000;

  typedef enum logic [3:0] {
    load_constant_word       = 4'h0,
    load_main_word           = 4'h1,
    load_scratch_word        = 4'h2,
    load_persistent_word     = 4'h3,
    compare_constant_word    = 4'h4,
    compare_main_word        = 4'h5,
    compare_scratch_word     = 4'h6,
    compare_persistent_word  = 4'h7,
    mask_with_constant_word  = 4'h8,
    mask_with_main_word      = 4'h9,
    mask_with_scratch_word   = 4'ha,
    mask_with_persistent_word = 4'hb
  } command_type;

  typedef struct packed {
    command_type                command;
    logic [WORD_WIDTH-1:0]      immediate_operand;
    logic [MAIN_ADDR_WIDTH-1:0] main_register_address;
    logic [SCR_NUM_WIDTH-1:0]   scratch_source_number;
    logic [PER_NUM_WIDTH-1:0]   persistent_register_number;
    logic [SCR_NUM_WIDTH-1:0]   scratch_result_number;
  } request_type;

  typedef struct packed {
    logic                       valid;
    logic [SCR_NUM_WIDTH-1:0]   number;
    logic [WORD_WIDTH-1:0]      data;
  } scratch_write_type;
endpackage

// ===== verif/store_model.sv
// register stores answering reads in the same cycle
`timescale 1ns/1ps
module store_model
  import word_alu_pkg::*;
(
  input  wire logic              clock,
  input  wire logic [10:0]       main_read_address,
  output logic [15:0]            main_read_data,
  input  wire logic [8:0]        scratch_read_number,
  output logic [15:0]            scratch_read_data,
  input  wire logic [5:0]        persistent_read_number,
  output logic [15:0]            persistent_read_data,
  input  wire scratch_write_type scratch_write
);
  logic [15:0] mem [512];
  initial for (int i = 0; i < 512; i++) mem[i] = {7'h2a, 9'(i)};
  assign main_read_data = {5'h15, main_read_address};
  assign scratch_read_data = mem[scratch_read_number];
  assign persistent_read_data = {10'h2b5, persistent_read_number};
  always @(posedge clock) begin
    if (scratch_write.valid)
      mem[scratch_write.number] <= scratch_write.data;
  end
endmodule

// ===== verif/word_alu_sva.sv
// port checks for the word accumulator unit
`timescale 1ns/1ps
module word_alu_sva
  import word_alu_pkg::*;
(
  input wire logic              clock,
  input wire logic              arst_n,
  input wire logic              command_valid,
  input wire request_type       request,
  input wire scratch_write_type scratch_write,
  input wire logic [15:0]       accumulator,
  input wire logic              command_done,
  input wire logic              operand_error,
  input wire logic [15:0]       main_read_data,
  input wire logic [15:0]       persistent_read_data
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  logic        v;
  command_type c;
  logic [15:0] k;
  logic [15:0] a;
  logic        mok;
  assign v = command_valid;
  assign c = request.command;
  assign k = request.immediate_operand;
  assign a = accumulator;
  assign mok = request.main_register_address < MAIN_COUNT;
  property p_done; v |=> command_done; endproperty
  a_done: assert property (p_done) else $error("no done");
  property p_idle; !v |=> !command_done && !scratch_write.valid; endproperty
  a_idle: assert property (p_idle) else $error("stray done");
  property p_ldk; v && c == load_constant_word |=> a == $past(k); endproperty
  a_ldk: assert property (p_ldk) else $error("load const");
  property p_ldm;
    v && c == load_main_word && mok |=> a == $past(main_read_data);
  endproperty
  a_ldm: assert property (p_ldm) else $error("load main");
  property p_ldp;
    v && c == load_persistent_word |=> a == $past(persistent_read_data);
  endproperty
  a_ldp: assert property (p_ldp) else $error("load pers");
  property p_andk;
    v && c == mask_with_constant_word |=> a == $past(a & k);
  endproperty
  a_andk: assert property (p_andk) else $error("mask const");
  property p_err;
    v && c == load_main_word && !mok |=> operand_error && $stable(a);
  endproperty
  a_err: assert property (p_err) else $error("bad address");
  property p_cmpk;
    v && c == compare_constant_word && request.scratch_result_number < 300
    |=> scratch_write.valid && scratch_write.data ==
        {12'h000, $past(a > k), $past(a == k), $past(a < k), 1'b0};
  endproperty
  a_cmpk: assert property (p_cmpk) else $error("cmp flags");
  c_err: cover property (operand_error);
  c_wr: cover property (scratch_write.valid);
  c_b2b: cover property (command_done ##2 command_done);
endmodule
bind word_accumulator_logic_unit word_alu_sva i_word_alu_sva (.*);

// ===== verif/tb.sv
// self-checking bench for the word accumulator unit
`timescale 1ns/1ps
module tb;
  import word_alu_pkg::*;
  logic              clock = 0;
  logic              arst_n = 0;
  logic              command_valid = 0;
  request_type       request = '0;
  logic [10:0]       main_read_address;
  logic [8:0]        scratch_read_number;
  logic [5:0]        persistent_read_number;
  logic [15:0]       main_read_data, scratch_read_data, persistent_read_data;
  logic [15:0]       accumulator, e;
  scratch_write_type scratch_write;
  logic              command_done, operand_error;
  int                n_errors = 0, num_checks = 0;
  always #2 clock = ~clock;
  word_accumulator_logic_unit i_word_accumulator_logic_unit (.*);
  store_model i_store_model (.*);
  task automatic chk(string n, logic [15:0] x, logic [15:0] g);
    num_checks++;
    if (g !== x) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic op(command_type c, logic [15:0] k, logic [10:0] m,
                    logic [8:0] s, logic [8:0] r);
    @(posedge clock);
    request <= '{c, k, m, s, s[5:0], r};
    command_valid <= 1;
    @(posedge clock);
    command_valid <= 0;
    #1 chk("done", 1, command_done);
  endtask
  task automatic t_load;
    op(load_constant_word, 16'hffff, 0, 0, 0);
    chk("ldk", 16'hffff, accumulator);
    op(load_main_word, 0, 11'h577, 0, 0);
    chk("ldm", {5'h15, 11'h577}, accumulator);
    op(load_scratch_word, 0, 0, 9'h12b, 0);
    chk("lds", {7'h2a, 9'h12b}, accumulator);
    op(load_persistent_word, 0, 0, 9'h03f, 0);
    chk("ldp", {10'h2b5, 6'h3f}, accumulator);
  endtask
  task automatic t_mask;
    op(load_constant_word, 16'hffff, 0, 0, 0);
    op(mask_with_constant_word, 16'h7ffe, 0, 0, 0);
    chk("andk", 16'h7ffe, accumulator);
    op(mask_with_main_word, 0, 11'h577, 0, 0);
    e = 16'h7ffe & {5'h15, 11'h577};
    chk("andm", e, accumulator);
    op(mask_with_scratch_word, 0, 0, 9'h12b, 0);
    e = e & {7'h2a, 9'h12b};
    chk("ands", e, accumulator);
    op(mask_with_persistent_word, 0, 0, 0, 0);
    chk("andp", e & 16'had40, accumulator);
  endtask
  task automatic cmp(command_type c, logic [15:0] k, logic [10:0] m,
                     logic [8:0] s, logic [15:0] x);
    op(c, k, m, s, 9'h007);
    chk("flags", x, scratch_write.data);
    chk("wnum", 16'h0007, 16'(scratch_write.number));
  endtask
  task automatic t_cmp;
    op(load_constant_word, 16'h1234, 0, 0, 0);
    cmp(compare_constant_word, 16'h1233, 0, 0, 16'h0008);
    cmp(compare_constant_word, 16'h1234, 0, 0, 16'h0004);
    cmp(compare_constant_word, 16'h1235, 0, 0, 16'h0002);
    cmp(compare_main_word, 0, 11'h000, 0, 16'h0002);
    cmp(compare_scratch_word, 0, 0, 9'h12b, 16'h0002);
    op(load_constant_word, 16'hffff, 0, 0, 0);
    cmp(compare_persistent_word, 0, 0, 9'h03f, 16'h0008);
  endtask
  task automatic t_err;
    op(load_main_word, 0, 11'h578, 0, 0);
    chk("err", 1, operand_error);
    chk("keep", 16'hffff, accumulator);
    op(compare_constant_word, 0, 0, 0, 9'h12c);
    chk("nowr", 0, scratch_write.valid);
    op(load_scratch_word, 0, 0, 9'h12c, 0);
    chk("err_scr", 1, operand_error);
    chk("keep_scr", 16'hffff, accumulator);
    op(command_type'(4'hc), 16'h0000, 0, 0, 0);
    chk("err_code", 1, operand_error);
    chk("keep_code", 16'hffff, accumulator);
    op(load_constant_word, 16'h0001, 0, 0, 0);
    chk("no_err", 0, operand_error);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clock);
    arst_n <= 1;
    t_load;
    t_mask;
    t_cmp;
    t_err;
    wrap_up;
  end
  // whole run needs well under this
  initial begin
    #2000;
    n_errors++;
    wrap_up;
  end
endmodule
